//--- wcs_defines.svh
// Constants for the weld cycle sequencer: register offsets, field positions,
// reset values and timing counts. Definitions only.
`ifndef WCS_DEFINES_SVH
`define WCS_DEFINES_SVH

`define WCS_ADDR_W          4
`define WCS_REG_CTRL        4'h0
`define WCS_REG_STATUS      4'h1
`define WCS_REG_START_TIME  4'h2
`define WCS_REG_CRATER_TIME 4'h3
`define WCS_REG_WELD_TIME   4'h4
`define WCS_REG_BURN_TIME   4'h5
`define WCS_REG_STRIKE_SET  4'h6
`define WCS_REG_START_SET   4'h7
`define WCS_REG_WELD_SET    4'h8
`define WCS_REG_CRATER_SET  4'h9
`define WCS_REG_FIRE_GAIN   4'hA

`define WCS_CTRL_START_OPT  0
`define WCS_CTRL_CRATER_OPT 1
`define WCS_CTRL_TIMER_OPT  2
`define WCS_CTRL_REV_BURN   3
`define WCS_CTRL_FAULT_CLR  4

`define WCS_CTRL_RESET      8'h00
`define WCS_TIME_RESET      16'h0010
`define WCS_SET_RESET       16'h8080
`define WCS_GAIN_RESET      8'h04

// Tick of the phase timers: 1 ms at a 10 ns clock
`define WCS_TICK_NS         1000000
`define WCS_CLK_NS          10
`define WCS_TICK_CYCLES     (`WCS_TICK_NS / `WCS_CLK_NS)
// Half cycle of the 60 Hz mains, in clock cycles
`define WCS_HALF_NS         8333333
`define WCS_HALF_CYCLES     (`WCS_HALF_NS / `WCS_CLK_NS)
// Gate pulse width of the drive firing logic
`define WCS_GATE_NS         10000
`define WCS_GATE_CYCLES     ((`WCS_GATE_NS + `WCS_CLK_NS - 1) / `WCS_CLK_NS)

`endif

//--- wcs_pkg.sv
// Types shared by the weld cycle sequencer and its motor drive.
// Assumes wcs_defines.svh is on the include path.
package wcs_pkg;

    typedef enum logic [2:0]
    {
        WCS_IDLE   = 3'b000,
        WCS_INCH   = 3'b001,
        WCS_STRIKE = 3'b010,
        WCS_START  = 3'b011,
        WCS_WELD   = 3'b100,
        WCS_CRATER = 3'b101,
        WCS_BURN   = 3'b110
    } wcs_phase_t;

    typedef struct packed
    {
        logic       run;
        logic       reverse;
        logic [7:0] speed;
    } wcs_motor_cmd_t;

    typedef struct packed
    {
        logic [7:0] speed;
        logic [7:0] volts;
    } wcs_setting_t;

endpackage : wcs_pkg

//--- wcs_motor_drive.sv
// Wire motor speed regulator and SCR gate firing for one armature supply.
// Assumes zero_cross_sync is already synchronised to clock.
`timescale 1ns/100ps
`include "wcs_defines.svh"

module wcs_motor_drive
    import wcs_pkg::*;
#(
    parameter int HALF_CYCLES = `WCS_HALF_CYCLES
)
(
    input  wire logic           clock,
    input  wire logic           resetn,
    input  wire wcs_motor_cmd_t cmd,
    input  wire logic [7:0]     tach,
    input  wire logic [7:0]     gain,
    input  wire logic           zero_cross_sync,
    output logic                gate_pulse,
    output logic [7:0]          drive_level
);

    typedef struct packed
    {
        logic [7:0]  level;
        logic [23:0] phase;
        logic [15:0] gate_cnt;
        logic        zc_d;
        logic        fired;
        logic        gate;
    } wcs_drv_state_t;

    wcs_drv_state_t s;
    wcs_drv_state_t next_s;
    logic [23:0]    fire_at;
    logic           zc_rise;

    assign zc_rise     = zero_cross_sync && !s.zc_d;
    assign gate_pulse  = s.gate;
    assign drive_level = s.level;
    // Higher level fires earlier in the half cycle
    assign fire_at = 24'((32'(8'hFF - s.level) * 32'(HALF_CYCLES)) >> 8);

    always_comb
    begin
        next_s      = s;
        next_s.zc_d = zero_cross_sync;
        if (zc_rise)
        begin
            // Integrating regulator: error against tach, once per half cycle
            if (!cmd.run)
                next_s.level = 8'h00;
            else if (cmd.speed > tach && s.level <= 8'(8'hFF - gain))
                next_s.level = s.level + gain;
            else if (cmd.speed > tach)
                next_s.level = 8'hFF;
            else if (cmd.speed < tach && s.level >= gain)
                next_s.level = s.level - gain;
            else if (cmd.speed < tach)
                next_s.level = 8'h00;
            next_s.phase = 24'h000000;
            next_s.fired = 1'b0;
        end
        else if (s.phase != 24'hFFFFFF)
            next_s.phase = s.phase + 24'h000001;
        if (s.gate_cnt != 16'h0000)
            next_s.gate_cnt = s.gate_cnt - 16'h0001;
        next_s.gate = (s.gate_cnt > 16'h0001);
        if (!zc_rise && !s.fired && s.level != 8'h00 && s.phase >= fire_at)
        begin
            next_s.fired    = 1'b1;
            next_s.gate_cnt = 16'(`WCS_GATE_CYCLES);
            next_s.gate     = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            s <= '0;
        else
            s <= next_s;
    end

    // Pulse length counted apart from gate_cnt, so a broken down-counter still shows
    logic [15:0] gate_len;
    always_ff @(posedge clock)
    begin
        if (!resetn)
            gate_len <= 16'h0000;
        else if (gate_pulse)
            gate_len <= gate_len + 16'h0001;
        else
            gate_len <= 16'h0000;
    end

    a_gate_short : assert property (@(posedge clock) disable iff (!resetn)
        gate_pulse |-> (gate_len < 16'(`WCS_GATE_CYCLES)))
        else $error("gate pulse too long");

    a_no_run_off : assert property (@(posedge clock) disable iff (!resetn)
        (!cmd.run && zc_rise) |=> (drive_level == 8'h00))
        else $error("drive level not cleared when stopped");

    c_gate_fired : cover property (@(posedge clock) disable iff (!resetn) $rose(gate_pulse));

endmodule : wcs_motor_drive

//--- wcs_sequencer.sv
// What this block does
// - On start, energise contactor, travel and flux relays together.
// - Inch down and stop switches set the matching motor drive conditions.
// - Inch up runs the motor in reverse, bypassing the sequencer.
// - Reed closure leaves strike for start phase if fitted, else weld.
// - Work touch during inch down stops the wire feed motor.
// - Arc voltage mismatch while welding shuts the cycle down with a fault.
// - After stop, wait the burnback delay before ending the cycle.
// - With reverse burnback, run the motor in reverse for the burnback time.
// - Start option settings hold for the set period, then weld settings.
// - Crater fill option: stop gives crater settings for a set period.
// - Weld timer option ends welding after the set time, as stop would.
// - Start, weld and crater present their own speed and volts; other phases present the strike settings.
// - Speed regulator combines command, setting and tach feedback.
// - Firing earlier raises output; each firing is a short gate pulse.
// Weld cycle sequencer top. Switch, reed, touch, mismatch and zero cross
// inputs are asynchronous pins; the register port runs on clock.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "wcs_defines.svh"

module wcs_sequencer
    import wcs_pkg::*;
#(
    parameter int TICK_CYCLES = `WCS_TICK_CYCLES,
    parameter int HALF_CYCLES = `WCS_HALF_CYCLES
)
(
    input  wire logic                 clock,
    input  wire logic                 resetn,
    input  wire logic [`WCS_ADDR_W-1:0] reg_addr,
    input  wire logic [15:0]          reg_wdata,
    input  wire logic                 reg_write,
    input  wire logic                 reg_read,
    output logic [15:0]               reg_rdata,
    input  wire logic                 start_sw,
    input  wire logic                 stop_sw,
    input  wire logic                 inch_down_sw,
    input  wire logic                 inch_up_sw,
    input  wire logic                 reed_sw,
    input  wire logic                 work_touch,
    input  wire logic                 volt_mismatch,
    input  wire logic                 zero_cross,
    input  wire logic [7:0]           tach,
    output logic                      contactor_relay_out,
    output logic                      travel_relay_out,
    output logic                      flux_relay_out,
    output logic                      sense_volt_on,
    output logic                      motor_reverse,
    output logic                      gate_pulse,
    output logic [7:0]                drive_level,
    output logic [7:0]                speed_ref,
    output logic [7:0]                volt_ref,
    output logic                      fault
);

    typedef struct packed
    {
        logic [7:0]   sync1;
        logic [7:0]   sync2;
        wcs_phase_t   phase;
        logic [31:0]  tick_cnt;
        logic [15:0]  ms_cnt;
        logic [7:0]   ctrl;
        logic [15:0]  start_time;
        logic [15:0]  crater_time;
        logic [15:0]  weld_time;
        logic [15:0]  burn_time;
        wcs_setting_t strike_set;
        wcs_setting_t start_set;
        wcs_setting_t weld_set;
        wcs_setting_t crater_set;
        logic [7:0]   gain;
        logic [15:0]  rdata;
        logic         contactor;
        logic         travel;
        logic         flux;
        logic         sense;
        logic         fault;
        wcs_motor_cmd_t cmd;
        wcs_setting_t out_set;
    } wcs_state_t;

    wcs_state_t   s;
    wcs_state_t   next_s;
    logic         start_i;
    logic         stop_i;
    logic         down_i;
    logic         up_i;
    logic         reed_i;
    logic         touch_i;
    logic         mism_i;
    logic         zc_i;
    logic         tick;
    wcs_setting_t sel;
    logic         gate_w;
    logic [7:0]   level_w;

    assign {zc_i, mism_i, touch_i, reed_i, up_i, down_i, stop_i, start_i} = s.sync2;
    assign tick = (s.tick_cnt == 32'(TICK_CYCLES - 1));

    assign contactor_relay_out = s.contactor;
    assign travel_relay_out    = s.travel;
    assign flux_relay_out      = s.flux;
    assign sense_volt_on       = s.sense;
    assign motor_reverse       = s.cmd.reverse;
    assign speed_ref           = s.out_set.speed;
    assign volt_ref            = s.out_set.volts;
    assign fault               = s.fault;
    assign reg_rdata           = s.rdata;

    // Settings of the start, weld or crater phase now running, else the strike settings
    always_comb
    begin
        unique case (s.phase)
            WCS_START:  sel = s.start_set;
            WCS_WELD:   sel = s.weld_set;
            WCS_CRATER: sel = s.crater_set;
            default:    sel = s.strike_set;
        endcase
    end

    always_comb
    begin
        next_s       = s;
        next_s.sync1 = {zero_cross, volt_mismatch, work_touch, reed_sw,
                        inch_up_sw, inch_down_sw, stop_sw, start_sw};
        next_s.sync2 = s.sync1;
        next_s.tick_cnt = tick ? 32'h0 : s.tick_cnt + 32'h1;
        if (tick && s.ms_cnt != 16'h0000)
            next_s.ms_cnt = s.ms_cnt - 16'h0001;
        next_s.ctrl[`WCS_CTRL_FAULT_CLR] = 1'b0;

        unique case (s.phase)
            WCS_IDLE:
            begin
                if (start_i && !s.fault)
                begin
                    next_s.phase     = WCS_STRIKE;
                    next_s.contactor = 1'b1;
                    next_s.travel    = 1'b1;
                    next_s.flux      = 1'b1;
                    next_s.sense     = 1'b0;
                end
                // Sense stays on after a touch, so a held switch cannot feed again
                else if (down_i && !s.sense)
                begin
                    next_s.phase = WCS_INCH;
                    next_s.sense = 1'b1;
                end
                else if (!down_i)
                    next_s.sense = 1'b0;
            end
            WCS_INCH:
            begin
                if (!down_i)
                begin
                    next_s.phase = WCS_IDLE;
                    next_s.sense = 1'b0;
                end
                else if (touch_i)
                    next_s.phase = WCS_IDLE;
            end
            WCS_STRIKE:
            begin
                if (stop_i)
                begin
                    next_s.phase  = WCS_BURN;
                    next_s.ms_cnt = s.burn_time;
                end
                else if (reed_i && s.ctrl[`WCS_CTRL_START_OPT])
                begin
                    next_s.phase  = WCS_START;
                    next_s.ms_cnt = s.start_time;
                end
                else if (reed_i)
                begin
                    next_s.phase  = WCS_WELD;
                    next_s.ms_cnt = s.weld_time;
                end
            end
            WCS_START:
            begin
                if (s.ms_cnt == 16'h0000)
                begin
                    next_s.phase  = WCS_WELD;
                    next_s.ms_cnt = s.weld_time;
                end
            end
            WCS_WELD:
            begin
                if (stop_i || (s.ctrl[`WCS_CTRL_TIMER_OPT] && s.ms_cnt == 16'h0000))
                begin
                    // Timer expiry takes the same path as stop
                    if (s.ctrl[`WCS_CTRL_CRATER_OPT])
                    begin
                        next_s.phase  = WCS_CRATER;
                        next_s.ms_cnt = s.crater_time;
                    end
                    else
                    begin
                        next_s.phase  = WCS_BURN;
                        next_s.ms_cnt = s.burn_time;
                    end
                end
            end
            WCS_CRATER:
            begin
                if (s.ms_cnt == 16'h0000)
                begin
                    next_s.phase  = WCS_BURN;
                    next_s.ms_cnt = s.burn_time;
                end
            end
            WCS_BURN:
            begin
                if (s.ms_cnt == 16'h0000)
                begin
                    next_s.phase     = WCS_IDLE;
                    next_s.contactor = 1'b0;
                    next_s.travel    = 1'b0;
                    next_s.flux      = 1'b0;
                end
            end
            default:
                next_s.phase = WCS_IDLE;
        endcase

        // Mismatch only counts once the arc is established
        if ((s.phase == WCS_WELD || s.phase == WCS_START || s.phase == WCS_CRATER) && mism_i)
        begin
            next_s.phase     = WCS_IDLE;
            next_s.fault     = 1'b1;
            next_s.contactor = 1'b0;
            next_s.travel    = 1'b0;
            next_s.flux      = 1'b0;
        end
        else if (s.ctrl[`WCS_CTRL_FAULT_CLR])
            next_s.fault = 1'b0;

        // Motor command; inch up overrides everything, even a weld
        next_s.out_set     = sel;
        next_s.cmd.speed   = sel.speed;
        next_s.cmd.reverse = 1'b0;
        next_s.cmd.run     = (s.phase == WCS_INCH) || (s.phase == WCS_START)
                             || (s.phase == WCS_STRIKE) || (s.phase == WCS_WELD)
                             || (s.phase == WCS_CRATER);
        if (s.phase == WCS_BURN)
        begin
            next_s.cmd.run     = s.ctrl[`WCS_CTRL_REV_BURN];
            next_s.cmd.reverse = s.ctrl[`WCS_CTRL_REV_BURN];
        end
        if (up_i)
        begin
            next_s.cmd.run     = 1'b1;
            next_s.cmd.reverse = 1'b1;
        end

        next_s.rdata = 16'h0000;
        if (reg_read)
        begin
            unique case (reg_addr)
                `WCS_REG_CTRL:        next_s.rdata = {8'h00, s.ctrl};
                `WCS_REG_STATUS:      next_s.rdata = {8'h00, 4'h0, s.fault, s.phase};
                `WCS_REG_START_TIME:  next_s.rdata = s.start_time;
                `WCS_REG_CRATER_TIME: next_s.rdata = s.crater_time;
                `WCS_REG_WELD_TIME:   next_s.rdata = s.weld_time;
                `WCS_REG_BURN_TIME:   next_s.rdata = s.burn_time;
                `WCS_REG_STRIKE_SET:  next_s.rdata = s.strike_set;
                `WCS_REG_START_SET:   next_s.rdata = s.start_set;
                `WCS_REG_WELD_SET:    next_s.rdata = s.weld_set;
                `WCS_REG_CRATER_SET:  next_s.rdata = s.crater_set;
                `WCS_REG_FIRE_GAIN:   next_s.rdata = {8'h00, s.gain};
                default:              next_s.rdata = 16'h0000;
            endcase
        end
        if (reg_write)
        begin
            unique case (reg_addr)
                `WCS_REG_CTRL:        next_s.ctrl        = reg_wdata[7:0];
                `WCS_REG_START_TIME:  next_s.start_time  = reg_wdata;
                `WCS_REG_CRATER_TIME: next_s.crater_time = reg_wdata;
                `WCS_REG_WELD_TIME:   next_s.weld_time   = reg_wdata;
                `WCS_REG_BURN_TIME:   next_s.burn_time   = reg_wdata;
                `WCS_REG_STRIKE_SET:  next_s.strike_set  = reg_wdata;
                `WCS_REG_START_SET:   next_s.start_set   = reg_wdata;
                `WCS_REG_WELD_SET:    next_s.weld_set    = reg_wdata;
                `WCS_REG_CRATER_SET:  next_s.crater_set  = reg_wdata;
                `WCS_REG_FIRE_GAIN:   next_s.gain        = reg_wdata[7:0];
                default:              next_s.gain        = s.gain;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            s             <= '0;
            s.ctrl        <= `WCS_CTRL_RESET;
            s.start_time  <= `WCS_TIME_RESET;
            s.crater_time <= `WCS_TIME_RESET;
            s.weld_time   <= `WCS_TIME_RESET;
            s.burn_time   <= `WCS_TIME_RESET;
            s.strike_set  <= `WCS_SET_RESET;
            s.start_set   <= `WCS_SET_RESET;
            s.weld_set    <= `WCS_SET_RESET;
            s.crater_set  <= `WCS_SET_RESET;
            s.gain        <= `WCS_GAIN_RESET;
        end
        else
            s <= next_s;
    end

    wcs_motor_drive #(.HALF_CYCLES(HALF_CYCLES)) u_drive
    (
        .clock           (clock),
        .resetn          (resetn),
        .cmd             (s.cmd),
        .tach            (tach),
        .gain            (s.gain),
        .zero_cross_sync (zc_i),
        .gate_pulse      (gate_w),
        .drive_level     (level_w)
    );

    // Registered once more so the top outputs come straight from flip-flops
    logic [8:0] drv_q;
    always_ff @(posedge clock)
    begin
        if (!resetn)
            drv_q <= 9'h000;
        else
            drv_q <= {gate_w, level_w};
    end
    assign gate_pulse  = drv_q[8];
    assign drive_level = drv_q[7:0];

    a_start_relays : assert property (@(posedge clock) disable iff (!resetn)
        (s.phase == WCS_IDLE && start_i && !s.fault) |=> (contactor_relay_out
        && travel_relay_out && flux_relay_out && s.phase == WCS_STRIKE))
        else $error("relays not energised on start");

    a_reed_phase : assert property (@(posedge clock) disable iff (!resetn)
        (s.phase == WCS_STRIKE && reed_i && !stop_i) |=>
        (s.phase == ($past(s.ctrl[`WCS_CTRL_START_OPT]) ? WCS_START : WCS_WELD)))
        else $error("wrong phase after reed closure");

    a_touch_stop : assert property (@(posedge clock) disable iff (!resetn)
        (s.phase == WCS_INCH && touch_i && !up_i) |=> ##1 !s.cmd.run)
        else $error("motor still running after work touch");

    a_mismatch_flt : assert property (@(posedge clock) disable iff (!resetn)
        (s.phase == WCS_WELD && mism_i) |=> (fault && !contactor_relay_out
        && s.phase == WCS_IDLE))
        else $error("mismatch did not shut down");

    a_inch_up_rev : assert property (@(posedge clock) disable iff (!resetn)
        up_i |=> (motor_reverse && s.cmd.run))
        else $error("inch up not reversing");

    a_burn_end : assert property (@(posedge clock) disable iff (!resetn)
        (s.phase == WCS_BURN && s.ms_cnt == 16'h0000) |=>
        (s.phase == WCS_IDLE && !contactor_relay_out && !flux_relay_out))
        else $error("relays held after burnback");

    a_weld_values : assert property (@(posedge clock) disable iff (!resetn)
        (s.phase == WCS_WELD) |=> ($past(s.phase) != WCS_WELD
        || speed_ref == $past(s.weld_set.speed)))
        else $error("weld settings not presented");

    a_rev_burn : assert property (@(posedge clock) disable iff (!resetn)
        (s.phase == WCS_BURN && s.ctrl[`WCS_CTRL_REV_BURN]) |=> motor_reverse)
        else $error("no reverse during burnback");

    a_timer_end : assert property (@(posedge clock) disable iff (!resetn)
        (s.phase == WCS_WELD && s.ctrl[`WCS_CTRL_TIMER_OPT] && s.ms_cnt == 16'h0000
        && !mism_i) |=> (s.phase == WCS_CRATER || s.phase == WCS_BURN))
        else $error("weld timer did not end weld");

    c_full_cycle : cover property (@(posedge clock) disable iff (!resetn)
        s.phase == WCS_BURN ##1 s.phase == WCS_IDLE);
    c_crater     : cover property (@(posedge clock) disable iff (!resetn)
        s.phase == WCS_CRATER);
    c_fault      : cover property (@(posedge clock) disable iff (!resetn) $rose(fault));
    c_start_opt  : cover property (@(posedge clock) disable iff (!resetn)
        s.phase == WCS_START ##1 s.phase == WCS_WELD);

endmodule : wcs_sequencer

//--- wcs_partner.sv
// Far side model: mains zero cross, wire motor tach and electrode touch.
// Assumes the sequencer clock and its drive level and sense outputs.
`timescale 1ns/100ps
module wcs_partner
#(
    parameter int HALF = 2000
)
(
    input  wire logic       clock,
    input  wire logic       sense_volt_on,
    input  wire logic [7:0] drive_level,
    output logic            zero_cross = 1'b0,
    output logic [7:0]      tach = 8'h00,
    output logic            work_touch = 1'b0
);
    int half_cnt = 0;
    int touch_cnt = 0;
    always @(posedge clock)
    begin
        half_cnt <= (half_cnt == HALF - 1) ? 0 : half_cnt + 1;
        zero_cross <= (half_cnt < 4);
        // Motor inertia: tach creeps toward the drive level, one step a cycle
        // An unknown level before reset leaves the tach alone
        if (drive_level > tach)
            tach <= tach + 8'h01;
        else if (drive_level < tach)
            tach <= tach - 8'h01;
        // Sense voltage collapses some time after the wire starts down
        touch_cnt <= sense_volt_on ? touch_cnt + 1 : 0;
        work_touch <= sense_volt_on && (touch_cnt > 40);
    end
endmodule : wcs_partner

//--- tb_weld_cycle_sequencer.sv
// Self-checking bench for the weld cycle sequencer and its partner model.
// Assumes wcs_defines.svh on the include path; timer tick shortened to 10 cycles.
`timescale 1ns/100ps
`include "wcs_defines.svh"
module tb_weld_cycle_sequencer;
    import wcs_pkg::*;
    logic        clock = 0, resetn = 0, reg_write = 0, reg_read = 0;
    logic [3:0]  reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata, d, weld_set;
    logic        start_sw = 0, stop_sw = 0, inch_down_sw = 0, inch_up_sw = 0;
    logic        reed_sw = 0, volt_mismatch = 0, zero_cross, work_touch, sense_volt_on;
    logic        contactor_relay_out, travel_relay_out, flux_relay_out, motor_reverse;
    logic        gate_pulse, fault;
    logic [7:0]  tach, drive_level, speed_ref, volt_ref;
    int          fails = 0, checked = 0, seed = 7799, n;
    logic [15:0] rv [12] = '{16'h0000, 16'h0000, 16'h0010, 16'h0010, 16'h0010, 16'h0010,
                             16'h8080, 16'h8080, 16'h8080, 16'h8080, 16'h0004, 16'h0000};
    logic [3:0]  opts [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
    always #5 clock = ~clock;
    wcs_sequencer #(.TICK_CYCLES(10), .HALF_CYCLES(2000)) DUT (.*);
    wcs_partner #(.HALF(2000)) partner (.clock(clock), .sense_volt_on(sense_volt_on),
        .drive_level(drive_level), .zero_cross(zero_cross), .tach(tach),
        .work_touch(work_touch));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clock);
        reg_write <= 1'b1; reg_addr <= a; reg_wdata <= v;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_read <= 1'b1; reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Polls status until the phase shows; a miss is reported by the compare
    task automatic wait_phase(input logic [2:0] p);
        for (n = 0; n < 200; n++)
        begin
            rd(4'h1);
            if (d[2:0] === p) break;
        end
        check(d[2:0], p);
    endtask : wait_phase
    task automatic relays(input logic [2:0] exp);
        check(3'({contactor_relay_out, travel_relay_out, flux_relay_out}), exp);
    endtask : relays
    task automatic press_start();
        @(posedge clock);
        start_sw <= 1'b1;
        repeat (3) @(posedge clock);
        #1 start_sw <= 1'b0;
    endtask : press_start
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    initial
    begin
        #500000;
        fails++;
        test_done();
    end
    initial
    begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            rd(4'(i));
            check(d, rv[i]);
        end
        wr(4'h2, 16'h0002); wr(4'h3, 16'h0002); wr(4'h4, 16'h0002); wr(4'h5, 16'h0003);
        foreach (opts[k])
        begin
            weld_set = 16'($random(seed));
            wr(4'h8, weld_set);
            wr(4'h0, 16'(opts[k]));
            press_start();
            relays(3'b111);
            wait_phase(WCS_STRIKE);
            check(speed_ref, 8'h80);
            reed_sw <= 1'b1;
            if (opts[k][0]) wait_phase(WCS_START);
            wait_phase(WCS_WELD);
            check({speed_ref, volt_ref}, weld_set);
            if (!opts[k][2]) stop_sw <= 1'b1;
            if (opts[k][1]) wait_phase(WCS_CRATER);
            wait_phase(WCS_BURN);
            stop_sw <= 1'b0;
            relays(3'b111);
            check(motor_reverse, opts[k][3]);
            wait_phase(WCS_IDLE);
            relays(3'b000);
            reed_sw <= 1'b0;
        end
        wr(4'h0, 16'h0000);
        press_start();
        reed_sw <= 1'b1;
        wait_phase(WCS_WELD);
        volt_mismatch <= 1'b1;
        repeat (6) @(posedge clock);
        #1 check(fault, 1'b1);
        relays(3'b000);
        rd(4'h1);
        check(d, 16'h0008);
        volt_mismatch <= 1'b0; reed_sw <= 1'b0;
        press_start();
        relays(3'b000);
        wr(4'h0, 16'h0010);
        repeat (2) @(posedge clock);
        #1 check(fault, 1'b0);
        @(posedge clock);
        inch_down_sw <= 1'b1;
        wait_phase(WCS_INCH);
        check(sense_volt_on, 1'b1);
        wait_phase(WCS_IDLE);
        rd(4'h1);
        check(d, 16'h0000);
        check(sense_volt_on, 1'b1);
        inch_down_sw <= 1'b0;
        inch_up_sw <= 1'b1;
        repeat (4) @(posedge clock);
        #1 check(motor_reverse, 1'b1);
        check(sense_volt_on, 1'b0);
        // Skip a pulse already under way so only a whole one is measured
        for (n = 0; n < 2000 && gate_pulse === 1'b1; n++) @(posedge clock) #1;
        for (n = 0; n < 6000 && gate_pulse !== 1'b1; n++) @(posedge clock) #1;
        check(drive_level != 8'h00, 1'b1);
        for (n = 0; n < 2000 && gate_pulse === 1'b1; n++) @(posedge clock) #1;
        check(16'(n), 16'(`WCS_GATE_CYCLES));
        inch_up_sw <= 1'b0;
        repeat (2100) @(posedge clock);
        #1 check(drive_level, 8'h00);
        test_done();
    end
endmodule : tb_weld_cycle_sequencer
